// >>> design/aoc_completer.sv
// Atomic-operation request decode, check, execute and completion build.
// Assumes a one-word memory port that answers a read while the strobe stands
// and a completion sink that accepts with a ready handshake.
`timescale 1ns/1ps

// Function
// - Failed atomic completes without data, format 00
// - Successful atomic completes with data, original value
// - Type 0 1100 decodes as fetch-add
// - Type 0 1101 decodes as swap
// - Type 0 1110 decodes as compare-and-swap
// - Reserved format/type never treated as atomic
// - Formats 10 and 11 select address width
// - Payload byte zero is least significant
// - Compare-and-swap second operand follows first directly
// - Store with same byte order as fetch
// - Read target before writing it
// - Completion bytes map like request bytes
// - Fetch-add combines fetched value with operand
// - 64-bit or 32-bit address headers accepted
// - Completion echoes requester id and tag
// - Byte-enable fields ignored for atomics
// - Non-architected length is malformed
// - Architected but unsupported size is unsupported
// - Lengths: one doubleword, compare-swap two
// - Compare value first, swap value second
// - Misaligned address is malformed for 32-bit operands
// - Errors reported against the receiving port
// - Add wraps, carry discarded
// - Compare-swap writes only on match
// - Swap writes unconditionally, returns old value
// - Byte count equals operand size; fixed at 4 here for every completion, 64- and 128-bit requests included
module aoc_completer
    import aoc_pkg::*;
#(
    parameter int AW = 64                       // Target memory address width
) (
    input  wire logic        core_clk_i,         // Transaction-layer clock
    input  wire logic        reset_n_i,          // Synchronous reset, active low
    input  wire logic        req_valid_i,        // Request present
    output logic             req_ready_o,        // Request taken when both high
    input  wire aoc_req_t    req_i,              // Parsed request
    input  wire logic        big_endian_i,       // Target memory byte order
    input  wire logic        support_32_i,       // 32-bit operands implemented
    output logic             mem_rd_o,           // Target read strobe
    output logic             mem_wr_o,           // Target write strobe
    output logic             mem_lock_o,         // Holds other masters off target
    output logic [AW-1:0]    mem_addr_o,         // Target word address (byte)
    output logic [31:0]      mem_wdata_o,        // Target write data, memory order
    input  wire logic [31:0] mem_rdata_i,        // Target read data, memory order
    output logic             cpl_valid_o,        // Completion present
    input  wire logic        cpl_ready_i,        // Completion sink ready
    output aoc_cpl_t         cpl_o,              // Completion
    output logic             err_malformed_o,    // Malformed pulse, this port
    output logic             err_unsup_o,        // Unsupported pulse, this port
    output logic             busy_o              // Operation in flight
);

    typedef enum {AOC_ST_IDLE, AOC_ST_READ, AOC_ST_WRITE, AOC_ST_CPL} aoc_state_t;

    aoc_state_t    state;                        // Sequencer state
    aoc_op_t       op;                           // Latched operation
    logic [31:0]   opnd_a;                       // Add, swap or compare value
    logic [31:0]   opnd_b;                       // Compare-and-swap swap value
    logic [31:0]   orig;                         // Fetched value, significance order
    logic          order_be;                     // Byte order latched for the whole op
    aoc_op_t       dec_op;                       // Decoded operation
    logic          dec_fmt_ok;                   // Format is 10 or 11
    logic          dec_len_arch;                 // Length is architected
    logic          dec_len_32;                   // Length names 32-bit operand
    logic          dec_misalign;                 // Address not naturally aligned
    logic          dec_malformed;                // Malformed outcome
    logic          dec_unsup;                    // Unsupported outcome
    logic          take;                         // Request taken this cycle
    logic [31:0]   next_result;                  // Value to store back
    logic          next_do_write;                // Store is needed

    // Swap byte order of a word
    function automatic logic [31:0] aoc_bswap(input logic [31:0] w);
        aoc_bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : aoc_bswap

    // Type decode; other types, or a bad format, are not atomics
    always_comb begin
        dec_fmt_ok = (req_i.fmt == AOC_FMT_3DW_D) || (req_i.fmt == AOC_FMT_4DW_D);
        case (req_i.tlp_type)
            AOC_TYPE_FADD: dec_op = AOC_OP_FADD;
            AOC_TYPE_SWAP: dec_op = AOC_OP_SWAP;
            AOC_TYPE_CAS:  dec_op = AOC_OP_CAS;
            default:       dec_op = AOC_OP_NONE;
        endcase
        if (!dec_fmt_ok) begin
            dec_op = AOC_OP_NONE;
        end
    end

    // Length and alignment checks; byte enables deliberately not looked at
    always_comb begin
        // 64-bit and 128-bit architected lengths are recognised but not built here
        if (dec_op == AOC_OP_CAS) begin
            dec_len_32   = (req_i.length == AOC_LEN_2DW);
            dec_len_arch = dec_len_32 || (req_i.length == 10'h004)
                           || (req_i.length == 10'h008);
        end else begin
            dec_len_32   = (req_i.length == AOC_LEN_1DW);
            dec_len_arch = dec_len_32 || (req_i.length == AOC_LEN_2DW);
        end
        // Alignment is checked only where the size is known and built
        dec_misalign  = dec_len_32 && (req_i.addr[1:0] != 2'h0);
        dec_malformed = (dec_op != AOC_OP_NONE) && (!dec_len_arch || dec_misalign);
        dec_unsup     = (dec_op != AOC_OP_NONE) && !dec_malformed
                        && (!dec_len_32 || !support_32_i);
    end

    assign req_ready_o = (state == AOC_ST_IDLE);
    assign take        = req_valid_i && req_ready_o;
    assign busy_o      = (state != AOC_ST_IDLE);

    // Compute the store-back value from the fetched value
    always_comb begin
        next_result   = orig;
        next_do_write = 1'b0;
        case (op)
            AOC_OP_FADD: begin
                next_result   = orig + opnd_a;   // Wraps at 32 bits
                next_do_write = 1'b1;
            end
            AOC_OP_SWAP: begin
                next_result   = opnd_a;
                next_do_write = 1'b1;
            end
            AOC_OP_CAS: begin
                next_result   = opnd_b;          // Swap value is second operand
                next_do_write = (orig == opnd_a);
            end
            default: begin
                next_result   = orig;
                next_do_write = 1'b0;
            end
        endcase
    end

    // Sequencer: read, then optional write, then completion
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state <= AOC_ST_IDLE;
        end else begin
            case (state)
                AOC_ST_IDLE: begin
                    if (take) begin
                        // Good requests fetch first; errored ones complete at once
                        if (dec_op != AOC_OP_NONE && !dec_malformed && !dec_unsup) begin
                            state <= AOC_ST_READ;
                        end else begin
                            state <= AOC_ST_CPL;
                        end
                    end
                end
                AOC_ST_READ:  state <= AOC_ST_WRITE;
                AOC_ST_WRITE: state <= AOC_ST_CPL;
                AOC_ST_CPL: begin
                    if (cpl_ready_i) begin
                        state <= AOC_ST_IDLE;
                    end
                end
                default: state <= AOC_ST_IDLE;
            endcase
        end
    end

    // Latch operands; payload is least-significant byte first
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            op       <= AOC_OP_NONE;
            opnd_a   <= 32'h0;
            opnd_b   <= 32'h0;
            order_be <= 1'b0;
        end else if (take) begin
            op       <= (dec_malformed || dec_unsup) ? AOC_OP_NONE : dec_op;
            opnd_a   <= req_i.payload[31:0];
            opnd_b   <= req_i.payload[63:32];
            order_be <= big_endian_i;      // Held for fetch and store alike
        end
    end

    // Capture fetched value, converted into significance order
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            orig <= 32'h0;
        end else if (state == AOC_ST_READ) begin
            orig <= order_be ? aoc_bswap(mem_rdata_i) : mem_rdata_i;
        end
    end

    // Memory port: strobes and address; lock covers fetch through store
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            mem_rd_o    <= 1'b0;
            mem_wr_o    <= 1'b0;
            mem_lock_o  <= 1'b0;
            mem_addr_o  <= '0;
            mem_wdata_o <= 32'h0;
        end else begin
            mem_rd_o <= take && (dec_op != AOC_OP_NONE) && !dec_malformed && !dec_unsup;
            mem_wr_o <= 1'b0;           // Pulse; raised below in the write slot only
            if (take) begin
                mem_addr_o <= req_i.addr[AW-1:0];
                mem_lock_o <= (dec_op != AOC_OP_NONE) && !dec_malformed && !dec_unsup;
            end else if (state == AOC_ST_WRITE) begin
                mem_wr_o    <= next_do_write;
                mem_wdata_o <= order_be ? aoc_bswap(next_result) : next_result;
            end else if (state == AOC_ST_CPL) begin
                mem_lock_o <= 1'b0;     // Released once store has been issued
            end
        end
    end

    // Completion build and error pulses
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cpl_o           <= '0;
            err_malformed_o <= 1'b0;
            err_unsup_o     <= 1'b0;
        end else begin
            err_malformed_o <= take && dec_malformed;
            err_unsup_o     <= take && (dec_unsup || dec_op == AOC_OP_NONE);
            if (take) begin
                cpl_o.req_id   <= req_i.req_id;
                cpl_o.tag      <= req_i.tag;
                cpl_o.byte_cnt <= AOC_BCNT_32;
                cpl_o.tlp_type <= AOC_TYPE_CPL;
                cpl_o.fmt      <= AOC_FMT_3DW_ND;
                cpl_o.length   <= 10'h000;
                cpl_o.data     <= 32'h0;
                cpl_o.status   <= dec_malformed ? AOC_CST_CA : AOC_CST_UR;
            end else if (state == AOC_ST_WRITE) begin
                cpl_o.fmt    <= AOC_FMT_3DW_D;
                cpl_o.length <= AOC_LEN_1DW;
                cpl_o.status <= AOC_CST_SC;
                cpl_o.data   <= orig;                     // Same byte map as request
            end
        end
    end

    assign cpl_valid_o = (state == AOC_ST_CPL);

    // Successful completion always carries data with the fixed type
    AST_CPL_WITH_DATA: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        cpl_valid_o && cpl_o.status == AOC_CST_SC |-> cpl_o.fmt == AOC_FMT_3DW_D
        && cpl_o.tlp_type == AOC_TYPE_CPL && cpl_o.length == AOC_LEN_1DW)
        else $error("Successful completion not sent with data");
    // Failed completion has no data
    AST_CPL_NO_DATA: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        cpl_valid_o && cpl_o.status != AOC_CST_SC |-> cpl_o.fmt == AOC_FMT_3DW_ND)
        else $error("Failed completion carries data");
    // Good atomic read then lock holds through write slot
    AST_READ_FIRST: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        mem_rd_o |-> mem_lock_o ##1 mem_lock_o ##1 mem_lock_o)
        else $error("Lock dropped during read-modify-write");
    // Write only ever two cycles after a read
    AST_WRITE_AFTER_READ: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        mem_wr_o |-> $past(mem_rd_o, 2))
        else $error("Write without prior read");
    // Misaligned 32-bit atomic flags malformed
    AST_MISALIGN: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        take && dec_op != AOC_OP_NONE && dec_len_32 && req_i.addr[1:0] != 2'h0
        |=> err_malformed_o && !mem_rd_o)
        else $error("Misaligned atomic not malformed");
    // Bad length flags malformed
    AST_BAD_LEN: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        take && dec_op == AOC_OP_FADD && req_i.length == 10'h003 |=> err_malformed_o)
        else $error("Bad length not malformed");
    // Fetch-add stores wrapped sum
    AST_FADD_SUM: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        state == AOC_ST_WRITE && op == AOC_OP_FADD && !order_be
        |=> mem_wr_o && mem_wdata_o == $past(orig) + $past(opnd_a))
        else $error("Fetch-add result wrong");
    // Compare mismatch never writes
    AST_CAS_MISS: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        state == AOC_ST_WRITE && op == AOC_OP_CAS && orig != opnd_a |=> !mem_wr_o)
        else $error("Compare-and-swap wrote on mismatch");
    // Completion echoes the transaction identifier
    AST_TID_ECHO: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        take |=> cpl_o.req_id == $past(req_i.req_id) && cpl_o.tag == $past(req_i.tag))
        else $error("Transaction identifier not echoed");

endmodule : aoc_completer

// >>> design/aoc_pkg.sv
// Package for the atomic-operation request completer.
// Assumes a single transaction-layer clock; headers arrive already parsed into fields.
package aoc_pkg;
    // Header format encodings
    localparam logic [1:0] AOC_FMT_3DW_ND = 2'h0;   // Header without data
    localparam logic [1:0] AOC_FMT_3DW_D  = 2'h2;   // 32-bit address, with data
    localparam logic [1:0] AOC_FMT_4DW_D  = 2'h3;   // 64-bit address, with data
    // Type encodings
    localparam logic [4:0] AOC_TYPE_CPL   = 5'h0a;  // Completion
    localparam logic [4:0] AOC_TYPE_FADD  = 5'h0c;  // Fetch and add
    localparam logic [4:0] AOC_TYPE_SWAP  = 5'h0d;  // Unconditional swap
    localparam logic [4:0] AOC_TYPE_CAS   = 5'h0e;  // Compare and swap
    // Architected lengths for 32-bit operands, in doublewords
    localparam logic [9:0] AOC_LEN_1DW    = 10'h001;
    localparam logic [9:0] AOC_LEN_2DW    = 10'h002;
    // Completion status codes
    localparam logic [2:0] AOC_CST_SC     = 3'h0;   // Successful
    localparam logic [2:0] AOC_CST_UR     = 3'h1;   // Unsupported request
    localparam logic [2:0] AOC_CST_CA     = 3'h4;   // Completer abort (malformed)
    // Operand size in bytes, reported in byte count
    localparam logic [11:0] AOC_BCNT_32   = 12'h004;

    typedef enum {AOC_OP_NONE, AOC_OP_FADD, AOC_OP_SWAP, AOC_OP_CAS} aoc_op_t;

    // Parsed request header plus payload (little-significance-first bytes)
    typedef struct packed {
        logic [1:0]  fmt;
        logic [4:0]  tlp_type;
        logic [9:0]  length;
        logic [15:0] req_id;
        logic [7:0]  tag;
        logic [3:0]  first_be;
        logic [3:0]  last_be;
        logic [63:0] addr;
        logic [63:0] payload;  // Byte 0 in [7:0]; second operand in [63:32]
    } aoc_req_t;

    // Completion header plus data
    typedef struct packed {
        logic [1:0]  fmt;
        logic [4:0]  tlp_type;
        logic [9:0]  length;
        logic [2:0]  status;
        logic [11:0] byte_cnt;
        logic [15:0] req_id;
        logic [7:0]  tag;
        logic [31:0] data;     // Original value, byte 0 least significant
    } aoc_cpl_t;
endpackage : aoc_pkg

// >>> sim/aoc_mem_model.sv
// Behavioural target memory standing behind the atomic completer.
// Assumes a one-word port whose read data is due in the cycle the strobe stands.
`timescale 1ns/1ps
module aoc_mem_model (
    input  wire logic        core_clk_i,   // Shared clock
    input  wire logic        reset_n_i,    // Synchronous reset, active low
    input  wire logic        mem_rd_i,     // Read strobe
    input  wire logic        mem_wr_i,     // Write strobe
    input  wire logic        mem_lock_i,   // Lock level
    input  wire logic [5:0]  mem_addr_i,   // Low byte address bits
    input  wire logic [31:0] mem_wdata_i,  // Write data, memory order
    output logic [31:0]      mem_rdata_o,  // Read data, memory order
    output logic             fault_o       // Sticky port-order fault
);
    logic [31:0] mem [16];  // Plain always below, so the bench may preload words
    logic        rd_open;   // A fetch awaits its store
    logic [5:0]  rd_addr;   // Address of that fetch
    logic [31:0] noise;     // Shown whenever no fetch strobe stands

    // Noise flips every cycle, so a fetch sampled at the wrong edge never passes
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            noise <= 32'h5a3c_96e1;
        end else begin
            noise <= ~noise;
        end
    end

    // Read data only while the strobe stands; the completer samples it then
    always_comb begin
        if (mem_rd_i) begin
            mem_rdata_o = mem[mem_addr_i[5:2]];
        end else begin
            mem_rdata_o = noise;
        end
    end

    // Store path and watch on fetch-then-store order under lock
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            rd_open <= 1'h0;
            fault_o <= 1'h0;
        end else begin
            if (mem_rd_i) begin
                rd_open <= 1'h1;
                rd_addr <= mem_addr_i;
            end
            if (mem_rd_i && !mem_lock_i) begin
                fault_o <= 1'h1;
            end
            if (mem_wr_i) begin
                mem[mem_addr_i[5:2]] <= mem_wdata_i;
                rd_open              <= 1'h0;
                if (!rd_open || rd_addr != mem_addr_i || !mem_lock_i) begin
                    fault_o <= 1'h1;
                end
            end
        end
    end
endmodule : aoc_mem_model

// >>> sim/aoc_completer_tb.sv
// Self-checking bench for the atomic completer: random and corner-case requests.
// Assumes aoc_mem_model as target; the bench is requester and completion sink.
`timescale 1ns/1ps
module aoc_completer_tb;
    import aoc_pkg::*;
    logic        core_clk, reset_n, req_valid, req_ready, big_endian, support_32;
    logic        mem_rd, mem_wr, mem_lock, cpl_valid, cpl_ready, err_mal, err_ur, busy;
    logic        fault;                  // Partner saw a bad port order
    logic [63:0] mem_addr;               // Target byte address
    logic [31:0] mem_wdata, mem_rdata;   // Target data, memory order
    aoc_req_t    req;                    // Request under test
    aoc_cpl_t    cpl;                    // Completion seen
    int          miscompares = 0;        // Mismatch counter
    int          cmp_count   = 0;        // Comparison counter
    int          seed        = 41527;    // Fixed seed keeps runs repeatable
    logic [6:0]  bad [7] = '{7'h0c, 7'h2d, 7'h4a, 7'h4b, 7'h6f, 7'h40, 7'h0a}; // {fmt,type}

    aoc_completer #(.AW(64)) aoc_completer_i (.core_clk_i(core_clk), .reset_n_i(reset_n),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_i(req),
        .big_endian_i(big_endian), .support_32_i(support_32), .mem_rd_o(mem_rd),
        .mem_wr_o(mem_wr), .mem_lock_o(mem_lock), .mem_addr_o(mem_addr),
        .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .cpl_valid_o(cpl_valid),
        .cpl_ready_i(cpl_ready), .cpl_o(cpl), .err_malformed_o(err_mal),
        .err_unsup_o(err_ur), .busy_o(busy));
    aoc_mem_model aoc_mem_model_i (.core_clk_i(core_clk), .reset_n_i(reset_n),
        .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .mem_lock_i(mem_lock),
        .mem_addr_i(mem_addr[5:0]), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata),
        .fault_o(fault));

    // 100 ns period
    always #50 core_clk = ~core_clk;

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    function automatic logic [31:0] swap32(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : swap32

    // Expected status; malformed length or misaligned 32-bit target beats unsupported
    function automatic logic [2:0] exp_status(input aoc_req_t r, input logic sup);
        logic cas;
        cas = (r.tlp_type == AOC_TYPE_CAS);
        if (!(r.fmt inside {AOC_FMT_3DW_D, AOC_FMT_4DW_D}) ||
            !(r.tlp_type inside {AOC_TYPE_FADD, AOC_TYPE_SWAP, AOC_TYPE_CAS})) return AOC_CST_UR;
        if (cas ? !(r.length inside {10'h002, 10'h004, 10'h008})
                : !(r.length inside {10'h001, 10'h002})) return AOC_CST_CA;
        if (r.length == (cas ? AOC_LEN_2DW : AOC_LEN_1DW) && r.addr[1:0] != 2'h0)
            return AOC_CST_CA;
        if (r.length != (cas ? AOC_LEN_2DW : AOC_LEN_1DW) || !sup) return AOC_CST_UR;
        return AOC_CST_SC;
    endfunction : exp_status

    // Value the target must hold after a successful operation
    function automatic logic [31:0] exp_store(input aoc_req_t r, input logic [31:0] orig);
        case (r.tlp_type)
            AOC_TYPE_FADD: return orig + r.payload[31:0];
            AOC_TYPE_SWAP: return r.payload[31:0];
            default:       return (orig == r.payload[31:0]) ? r.payload[63:32] : orig;
        endcase
    endfunction : exp_store

    // Legal random request; enables are scrambled since they must be ignored
    function automatic aoc_req_t rnd_req(input logic [4:0] ty, input logic f64);
        aoc_req_t r;
        r.fmt      = f64 ? AOC_FMT_4DW_D : AOC_FMT_3DW_D;
        r.tlp_type = ty;
        r.length   = (ty == AOC_TYPE_CAS) ? AOC_LEN_2DW : AOC_LEN_1DW;
        r.req_id   = 16'($random(seed));
        r.tag      = 8'($random(seed));
        {r.first_be, r.last_be} = 8'($random(seed));
        r.addr     = {f64 ? 32'($random(seed)) : 32'h0, 30'($random(seed)), 2'h0};
        r.payload  = {32'($random(seed)), 32'($random(seed))};
        return r;
    endfunction : rnd_req

    // One request from take to acceptance, with a random completion stall
    task automatic run(input aoc_req_t r, input logic be, input logic sup,
                       input logic [31:0] orig);
        logic [2:0]  st;
        logic [31:0] nv;
        int          n;
        st = exp_status(r, sup);
        nv = (st == AOC_CST_SC) ? exp_store(r, orig) : orig;
        aoc_mem_model_i.mem[r.addr[5:2]] = be ? swap32(orig) : orig;
        check("ready when idle", 1, req_ready);
        req = r;
        big_endian = be;
        support_32 = sup;
        req_valid = 1'h1;
        @(posedge core_clk);
        #1 req_valid = 1'h0;
        check("ready while busy", 0, req_ready);
        check("busy", 1, busy);
        n = 1;
        while (!cpl_valid && n < 10) begin
            @(posedge core_clk);
            #1 n++;
        end
        check("answer latency", (st == AOC_CST_SC) ? 3 : 1, n);
        check("malformed pulse", st == AOC_CST_CA, err_mal);
        check("unsupported pulse", st == AOC_CST_UR, err_ur);
        check("status", st, cpl.status);
        check("format", (st == AOC_CST_SC) ? 2'h2 : 2'h0, cpl.fmt);
        check("type", AOC_TYPE_CPL, cpl.tlp_type);
        check("length", (st == AOC_CST_SC) ? 1 : 0, cpl.length);
        check("byte count", AOC_BCNT_32, cpl.byte_cnt);
        check("transaction id", {r.req_id, r.tag}, {cpl.req_id, cpl.tag});
        if (st == AOC_CST_SC) check("original", orig, cpl.data);
        repeat ($unsigned($random(seed)) % 4) @(posedge core_clk);
        #1 check("completion held", 1, cpl_valid);
        cpl_ready = 1'h1;
        @(posedge core_clk);
        #1 cpl_ready = 1'h0;
        check("stored", be ? swap32(nv) : nv, aoc_mem_model_i.mem[r.addr[5:2]]);
    endtask : run

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog: far beyond the roughly 650 cycles the sequence needs
    initial begin
        #(100 * 20000);
        miscompares++;
        report_and_stop();
    end

    initial begin
        aoc_req_t    r;
        logic [31:0] o;
        core_clk = 1'h0;
        reset_n = 1'h0;
        req_valid = 1'h0;
        req = '0;
        big_endian = 1'h0;
        support_32 = 1'h1;
        cpl_ready = 1'h0;
        repeat (20) @(posedge core_clk);
        #1 reset_n = 1'h1;
        check("reset outputs", 7'h40, {req_ready, cpl_valid, busy, mem_rd, mem_wr, mem_lock,
                                       err_mal | err_ur});
        // Each code, both formats and byte orders; carry-out add, CAS hit and miss
        for (int k = 0; k < 16; k++) begin
            r = rnd_req((k % 4 == 0) ? AOC_TYPE_FADD : (k % 4 == 1) ? AOC_TYPE_SWAP
                                                                    : AOC_TYPE_CAS, k[2]);
            o = (k % 4 == 0) ? 32'hffff_fff0 : 32'($random(seed));
            if (k % 4 == 2) r.payload[31:0] = o;
            run(r, k[3], 1'h1, o);
        end
        // Reserved and non-atomic format/type pairs
        foreach (bad[i]) begin
            r = rnd_req(bad[i][4:0], 1'h0);
            r.fmt = bad[i][6:5];
            run(r, 1'h0, 1'h1, 32'($random(seed)));
        end
        // Length sweep 0..9 for single- and double-operand codes
        for (int k = 0; k < 20; k++) begin
            r = rnd_req((k < 10) ? AOC_TYPE_FADD : AOC_TYPE_CAS, k[0]);
            r.length = 10'(k % 10);
            run(r, 1'h0, 1'h1, 32'($random(seed)));
        end
        // Misaligned targets plus one aligned compare-and-swap, then 32-bit operands switched off
        for (int k = 1; k < 7; k++) begin
            r = rnd_req(k[0] ? AOC_TYPE_SWAP : AOC_TYPE_CAS, 1'h1);
            r.addr[1:0] = k[1:0];
            run(r, 1'h1, 1'h1, 32'($random(seed)));
        end
        for (int k = 0; k < 3; k++) begin
            run(rnd_req(5'(AOC_TYPE_FADD + k), 1'h0), 1'h0, 1'h0, 32'($random(seed)));
        end
        // Random traffic, a quarter with header fields scrambled
        repeat (80) begin
            r = rnd_req(5'(AOC_TYPE_FADD + $unsigned($random(seed)) % 3), 1'($random(seed)));
            if (($random(seed) & 3) == 0) begin
                r.fmt = 2'($random(seed));
                r.tlp_type = 5'($random(seed));
                r.length = 10'($random(seed) & 15);
                r.addr[1:0] = 2'($random(seed));
            end
            run(r, 1'($random(seed)), 1'h1, 32'($random(seed)));
        end
        check("memory port order", 0, fault);
        report_and_stop();
    end
endmodule : aoc_completer_tb
